// ---- logic/scir_config_regs.sv ----
// Purpose: serial-reached configuration and identification bank of a converter
// Assumes: mode 0 serial link, 16-bit instruction (read flag, 15-bit address) then data bytes
// Notes: serial pins are oversampled by clk, so the serial clock must run well below clk/6
`timescale 1ns/1ps
`default_nettype none
`include "scir_regs.svh"

// Operation
// - writing one to the top interface bit resets every register, itself included
// - that reset bit clears itself and always reads zero
// - stream direction bit: zero decrements address, one (default) increments
// - interface register reads 0x30 after reset; bit four always one
// - two-bit power mode: zero normal, three full power-down; one, two reserved
// - part class low nibble is a fixed read-only class code
// - part identifier is fixed 16 bits read as two consecutive bytes
// - silicon revision is a fixed read-only byte
// - maker code is fixed 16 bits at two bytes from offset 0xC
// - mismatch-shaping bytes at 0x727, 0x729; output offset in 0x72A to 0x72D
module scir_config_regs #(
	parameter logic [3:0] CLASS_CODE = 4'h9,      // arbitrary value
	parameter logic [15:0] PART_ID = 16'h1234,    // arbitrary value
	parameter logic [7:0] SILICON_REV = 8'h21,    // arbitrary value
	parameter logic [15:0] MAKER_ID = 16'h00A5    // arbitrary value
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic spiSclk,
	input wire logic spiCsN,
	input wire logic spiSdi,
	output logic spiSdo,
	output logic spiSdoEn,
	output logic [1:0] powerMode,
	output logic streamAscend,
	output logic [7:0] mismatchShapingAdjust,
	output logic [7:0] mismatchShapingDitherCtrl,
	output logic [31:0] outputOffsetAdjust,
	output logic chipResetReq
);

	localparam scir_pkg::scir_regs_t REGS_RESET = '{
		ifCfg: `SCIR_IFCFG_RESET,
		pwrCfg: `SCIR_PWR_RESET,
		classRsv: `SCIR_CLASS_RSV_RESET,
		demAdj: `SCIR_DEM_RESET,
		demDith: `SCIR_DEM_RESET,
		ofs: `SCIR_OFS_RESET
	};
	localparam logic [2:0] PIN_RST = 3'h2;  // chip select idles high

	scir_pkg::scir_state_t s;
	scir_pkg::scir_state_t next_s;
	logic [2:0] pinRaw;
	logic [2:0] pinLvl;
	logic sclkLvl;
	logic csNLvl;
	logic sdiLvl;
	logic sclkRise;
	logic sclkFall;
	logic wrStb;
	logic [14:0] wrAddr;
	logic [7:0] wrData;
	logic stepStb;
	logic [7:0] rdData;
	logic [15:0] shiftNext;
	logic [14:0] stepAddr;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	assign pinRaw = {spiSclk, spiCsN, spiSdi};
	for (genvar g = 0; g < 3; g++) begin : gSync
		scir_pin_sync #(
			.RST_LEVEL(PIN_RST[g])
		) uSync (
			.clk(clk),
			.reset(reset),
			.pinIn(pinRaw[g]),
			.level(pinLvl[g])
		);
	end
	assign sclkLvl = pinLvl[2];
	assign csNLvl = pinLvl[1];
	assign sdiLvl = pinLvl[0];
	assign sclkRise = sclkLvl && !s.link.prevSclk;
	assign sclkFall = !sclkLvl && s.link.prevSclk;

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	// unlisted and reserved addresses read zero
	function automatic logic [7:0] readByte(input scir_pkg::scir_regs_t r, input logic [14:0] a);
		logic [4:0] ofsBit;
		ofsBit = {a[1:0] - 2'h2, 3'h0};
		readByte = 8'h00;
		case (a)
			`SCIR_ADDR_IFCFG: readByte = r.ifCfg;
			`SCIR_ADDR_PWR: readByte = r.pwrCfg;
			`SCIR_ADDR_CLASS: readByte = {r.classRsv, CLASS_CODE};
			`SCIR_ADDR_PID_LO: readByte = PART_ID[7:0];
			`SCIR_ADDR_PID_HI: readByte = PART_ID[15:8];
			`SCIR_ADDR_REV: readByte = SILICON_REV;
			`SCIR_ADDR_MAKER_LO: readByte = MAKER_ID[7:0];
			`SCIR_ADDR_MAKER_HI: readByte = MAKER_ID[15:8];
			`SCIR_ADDR_DEMADJ: readByte = r.demAdj;
			`SCIR_ADDR_DEMDITH: readByte = r.demDith;
			default: begin
				if (a >= `SCIR_ADDR_OFS0 && a <= `SCIR_ADDR_OFS3) begin
					readByte = r.ofs[ofsBit +: 8];
				end
			end
		endcase
	endfunction : readByte

	assign rdData = readByte(s.regs, s.link.addr);

	// ----------------------------------------
	// serial engine and register writes
	// ----------------------------------------
	always_comb begin
		next_s = s;
		wrStb = 1'b0;
		wrAddr = s.link.addr;
		wrData = 8'h00;
		stepStb = 1'b0;
		shiftNext = {s.link.shift[14:0], sdiLvl};
		stepAddr = s.regs.ifCfg[`SCIR_ASC_BIT] ? s.link.addr + 15'h0001 : s.link.addr - 15'h0001;
		next_s.link.prevSclk = sclkLvl;
		if (s.chipRst != 4'h0) begin
			next_s.chipRst = s.chipRst - 4'h1;
		end
		if (csNLvl) begin
			// frame over: release the data line
			next_s.link.phase = scir_pkg::SCIR_IDLE;
			next_s.link.bitCnt = 5'h00;
			next_s.link.sdoEn = 1'b0;
		end else if (sclkRise) begin
			next_s.link.shift = shiftNext;
			next_s.link.bitCnt = s.link.bitCnt + 5'h01;
			case (s.link.phase)
				scir_pkg::SCIR_DATA: begin
					if (s.link.bitCnt == `SCIR_BYTE_LAST) begin
						next_s.link.bitCnt = 5'h00;
						stepStb = 1'b1;
						wrStb = !s.link.isRead;
						wrData = shiftNext[7:0];
						next_s.link.addr = stepAddr;
						next_s.link.txByte = readByte(s.regs, stepAddr);
					end
				end
				default: begin
					next_s.link.phase = scir_pkg::SCIR_INSTR;
					if (s.link.bitCnt == `SCIR_INSTR_LAST) begin
						next_s.link.phase = scir_pkg::SCIR_DATA;
						next_s.link.bitCnt = 5'h00;
						next_s.link.isRead = shiftNext[15];
						next_s.link.addr = shiftNext[14:0];
						next_s.link.txByte = readByte(s.regs, shiftNext[14:0]);
					end
				end
			endcase
		end else if (sclkFall && s.link.phase == scir_pkg::SCIR_DATA && s.link.isRead) begin
			// launch next read bit, msb first
			next_s.link.sdo = s.link.txByte[7];
			next_s.link.txByte = {s.link.txByte[6:0], 1'b0};
			next_s.link.sdoEn = 1'b1;
		end
		if (wrStb) begin
			case (wrAddr)
				`SCIR_ADDR_IFCFG: begin
					if (wrData[`SCIR_SRST_BIT]) begin
						next_s.regs = REGS_RESET;
						next_s.chipRst = `SCIR_SRST_CYC;
					end else begin
						next_s.regs.ifCfg = wrData;
						next_s.regs.ifCfg[`SCIR_SRST_BIT] = 1'b0;
						next_s.regs.ifCfg[`SCIR_FIXED_BIT] = 1'b1;
					end
				end
				`SCIR_ADDR_PWR: next_s.regs.pwrCfg = wrData;
				`SCIR_ADDR_CLASS: next_s.regs.classRsv = wrData[7:4];
				`SCIR_ADDR_DEMADJ: next_s.regs.demAdj = wrData;
				`SCIR_ADDR_DEMDITH: next_s.regs.demDith = wrData;
				default: begin
					if (wrAddr >= `SCIR_ADDR_OFS0 && wrAddr <= `SCIR_ADDR_OFS3) begin
						next_s.regs.ofs[{wrAddr[1:0] - 2'h2, 3'h0} +: 8] = wrData;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '{regs: REGS_RESET, link: '{phase: scir_pkg::SCIR_IDLE, default: '0}, chipRst: 4'h0};
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign spiSdo = s.link.sdo;
	assign spiSdoEn = s.link.sdoEn;
	assign powerMode = s.regs.pwrCfg[1:0];
	assign streamAscend = s.regs.ifCfg[`SCIR_ASC_BIT];
	assign mismatchShapingAdjust = s.regs.demAdj;
	assign mismatchShapingDitherCtrl = s.regs.demDith;
	assign outputOffsetAdjust = s.regs.ofs;
	assign chipResetReq = s.chipRst != 4'h0;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_srst_reload: assert property (@(posedge clk) disable iff (reset)
		wrStb && wrAddr == `SCIR_ADDR_IFCFG && wrData[`SCIR_SRST_BIT]
		|=> s.regs == REGS_RESET && chipResetReq)
		else $error("soft reset did not restore registers");
	a_srst_selfclr: assert property (@(posedge clk) disable iff (reset)
		!s.regs.ifCfg[`SCIR_SRST_BIT] && !(s.link.addr == `SCIR_ADDR_IFCFG && rdData[`SCIR_SRST_BIT]))
		else $error("reset bit reads one");
	a_stream_step: assert property (@(posedge clk) disable iff (reset)
		stepStb |=> s.link.addr == ($past(streamAscend) ? $past(s.link.addr) + 15'h0001
			: $past(s.link.addr) - 15'h0001))
		else $error("stream address stepped wrong way");
	a_reset_value: assert property (@(posedge clk)
		$past(reset) && !reset |-> s.regs.ifCfg == `SCIR_IFCFG_RESET)
		else $error("interface register reset value wrong");
	a_fixed_one: assert property (@(posedge clk) disable iff (reset) s.regs.ifCfg[`SCIR_FIXED_BIT])
		else $error("fixed bit not one");
	a_power_mode: assert property (@(posedge clk) disable iff (reset)
		wrStb && wrAddr == `SCIR_ADDR_PWR |=> powerMode == $past(wrData[1:0]))
		else $error("power mode not updated");
	a_class_code: assert property (@(posedge clk) disable iff (reset)
		s.link.addr == `SCIR_ADDR_CLASS |-> rdData[3:0] == CLASS_CODE)
		else $error("class code altered");
	a_part_id: assert property (@(posedge clk) disable iff (reset)
		s.link.addr == `SCIR_ADDR_PID_HI |-> rdData == PART_ID[15:8])
		else $error("part identifier high byte wrong");
	a_rev_code: assert property (@(posedge clk) disable iff (reset)
		s.link.addr == `SCIR_ADDR_REV |-> rdData == SILICON_REV)
		else $error("revision byte wrong");
	a_maker_code: assert property (@(posedge clk) disable iff (reset)
		s.link.addr == `SCIR_ADDR_MAKER_LO |-> rdData == MAKER_ID[7:0])
		else $error("maker code low byte wrong");
	a_offset_write: assert property (@(posedge clk) disable iff (reset)
		wrStb && wrAddr == `SCIR_ADDR_OFS3 |=> outputOffsetAdjust[31:24] == $past(wrData))
		else $error("offset top byte not written");
	a_rsv_keep: assert property (@(posedge clk) disable iff (reset)
		wrStb && wrAddr == `SCIR_ADDR_IFCFG && !wrData[`SCIR_SRST_BIT]
		|=> s.regs.ifCfg[3:0] == $past(wrData[3:0]) && s.regs.ifCfg[6] == $past(wrData[6]))
		else $error("reserved bits not kept");

endmodule : scir_config_regs

`default_nettype wire

// ---- logic/scir_regs.svh ----
// Purpose: addresses, field positions, reset values and timing counts of the configuration bank
// Assumes: 15-bit register address, byte-wide registers
// Notes: definitions only
`ifndef SCIR_REGS_SVH
`define SCIR_REGS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define SCIR_ADDR_IFCFG 15'h0000
`define SCIR_ADDR_PWR 15'h0002
`define SCIR_ADDR_CLASS 15'h0003
`define SCIR_ADDR_PID_LO 15'h0004
`define SCIR_ADDR_PID_HI 15'h0005
`define SCIR_ADDR_REV 15'h0006
`define SCIR_ADDR_MAKER_LO 15'h000C
`define SCIR_ADDR_MAKER_HI 15'h000D
`define SCIR_ADDR_DEMADJ 15'h0727
`define SCIR_ADDR_DEMDITH 15'h0729
`define SCIR_ADDR_OFS0 15'h072A
`define SCIR_ADDR_OFS3 15'h072D

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SCIR_SRST_BIT 7
`define SCIR_ASC_BIT 5
`define SCIR_FIXED_BIT 4
`define SCIR_IFCFG_RESET 8'h30
`define SCIR_PWR_RESET 8'h00
`define SCIR_CLASS_RSV_RESET 4'h0
`define SCIR_DEM_RESET 8'h00
`define SCIR_OFS_RESET 32'h0000_0000
`define SCIR_MODE_NORMAL 2'h0
`define SCIR_MODE_PDN 2'h3

// ----------------------------------------
// serial framing and timing
// ----------------------------------------
`define SCIR_INSTR_LAST 5'h0F
`define SCIR_BYTE_LAST 5'h07
`define SCIR_CLK_NS 50
`define SCIR_SRST_NS 5
`define SCIR_SRST_CYC_RAW (`SCIR_SRST_NS / `SCIR_CLK_NS)
`define SCIR_SRST_CYC ((`SCIR_SRST_CYC_RAW < 1) ? 4'h1 : 4'(`SCIR_SRST_CYC_RAW))

`endif

// ---- logic/scir_pkg.sv ----
// Purpose: types shared by the configuration bank
// Assumes: nothing
// Notes: state of each module is one packed struct
package scir_pkg;

	// serial frame phase, gray along idle -> instruction -> data
	typedef enum logic [1:0] {
		SCIR_IDLE = 2'h0,
		SCIR_INSTR = 2'h1,
		SCIR_DATA = 2'h3
	} scir_phase_t;

	typedef struct packed {
		logic [7:0] ifCfg;
		logic [7:0] pwrCfg;
		logic [3:0] classRsv;
		logic [7:0] demAdj;
		logic [7:0] demDith;
		logic [31:0] ofs;
	} scir_regs_t;

	typedef struct packed {
		scir_phase_t phase;
		logic [4:0] bitCnt;
		logic [15:0] shift;
		logic isRead;
		logic [14:0] addr;
		logic [7:0] txByte;
		logic sdo;
		logic sdoEn;
		logic prevSclk;
	} scir_link_t;

	typedef struct packed {
		scir_regs_t regs;
		scir_link_t link;
		logic [3:0] chipRst;
	} scir_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} scir_sync_t;

endpackage : scir_pkg

// ---- logic/scir_pin_sync.sv ----
// Purpose: three-flop synchroniser with agreement filter for one pin
// Assumes: pin is asynchronous to clk
// Notes: level changes only once the second and third flops agree
`timescale 1ns/1ps
`default_nettype none

module scir_pin_sync #(
	parameter logic RST_LEVEL = 1'b0
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic pinIn,
	output logic level
);

	scir_pkg::scir_sync_t s;
	scir_pkg::scir_sync_t next_s;

	// ----------------------------------------
	// shift chain and filter
	// ----------------------------------------
	// first flop feeds only the second
	always_comb begin
		next_s = s;
		next_s.s1 = pinIn;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		if (s.s2 == s.s3) begin
			next_s.level = s.s3;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= {RST_LEVEL, RST_LEVEL, RST_LEVEL, RST_LEVEL};
		end else begin
			s <= next_s;
		end
	end

	assign level = s.level;

endmodule : scir_pin_sync

`default_nettype wire

// ---- verif/scir_spi_host.sv ----
// Purpose: serial host model driving the configuration bank in mode 0, msb first
// Assumes: sclk high phase lasts 8 clk and low phase 9 clk, well above the bank's oversampling need
// Notes: frame() sends instruction and data, reports every read byte on rdStrobe
`timescale 1ns/1ps
`default_nettype none

module scir_spi_host (
	input wire logic clk,
	input wire logic sdo,
	input wire logic sdoEn,
	output logic sclk,
	output logic csN,
	output logic sdi,
	output logic rdStrobe,
	output logic [7:0] rdByte
);
	// ----------------------------------------
	// idle levels
	// ----------------------------------------
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		sdi = 1'b0;
		rdStrobe = 1'b0;
		rdByte = 8'h00;
	end

	// ----------------------------------------
	// one frame
	// ----------------------------------------
	// bytes go out low byte of wd first; read bits taken at sclk rise
	task frame(input logic rd, input logic [14:0] a, input int n, input logic [31:0] wd);
		logic [47:0] bits;
		logic [7:0] b;
		int i;
		bits = {rd, a, wd[7:0], wd[15:8], wd[23:16], wd[31:24]};
		@(posedge clk) csN <= 1'b0;
		repeat (8) @(posedge clk);
		for (i = 0; i < 16 + 8 * n; i++) begin
			sdi <= bits[47-i];
			repeat (8) @(posedge clk);
			sclk <= 1'b1;
			b = {b[6:0], sdoEn ? sdo : 1'bx};
			repeat (8) @(posedge clk);
			sclk <= 1'b0;
			rdStrobe <= rd && i >= 23 && i % 8 == 7;
			rdByte <= b;
			@(posedge clk) rdStrobe <= 1'b0;
		end
		// sclk stands low; released data line shows the inverse level
		@(posedge clk) csN <= 1'b1;
		sdi <= ~sdi;
		repeat (8) @(posedge clk);
	endtask : frame
endmodule : scir_spi_host

`default_nettype wire

// ---- verif/spi_config_ident_regs_tb_top.sv ----
// Purpose: self-checking bench of the configuration and identification bank
// Assumes: host model drives every serial input pin
// Notes: read bytes are checked against a queue of expected bytes
`timescale 1ns/1ps
`default_nettype none

module spi_config_ident_regs_tb_top;
	localparam logic [3:0] CLS = 4'h6; // arbitrary value
	localparam logic [15:0] PID = 16'h5a3c; // arbitrary value
	localparam logic [7:0] REV = 8'h17; // arbitrary value
	localparam logic [15:0] MKR = 16'hc3e1; // arbitrary value
	logic clk, reset, sclk, csN, sdi, sdo, sdoEn, asc, crq, rdStrobe;
	logic [1:0] pm;
	logic [7:0] dAdj, dDith, rdByte;
	logic [31:0] ofs, rng, r;
	logic [7:0] expQ[$];
	int num_errors, samples_checked, rstPulses, i;

	// ----------------------------------------
	// design and host
	// ----------------------------------------
	scir_config_regs #(.CLASS_CODE(CLS), .PART_ID(PID), .SILICON_REV(REV), .MAKER_ID(MKR)) DUT (
		.clk(clk), .reset(reset), .spiSclk(sclk), .spiCsN(csN), .spiSdi(sdi), .spiSdo(sdo),
		.spiSdoEn(sdoEn), .powerMode(pm), .streamAscend(asc), .mismatchShapingAdjust(dAdj),
		.mismatchShapingDitherCtrl(dDith), .outputOffsetAdjust(ofs), .chipResetReq(crq));
	scir_spi_host host (.clk(clk), .sdo(sdo), .sdoEn(sdoEn), .sclk(sclk), .csN(csN), .sdi(sdi),
		.rdStrobe(rdStrobe), .rdByte(rdByte));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs

	task check_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: read %h expected %h", $time, got, exp);
		end
	endtask : check_byte

	task check_port(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: port %h expected %h", $time, got, exp);
		end
	endtask : check_port

	// note expected bytes, then run the read frame
	task rd(input logic [14:0] a, input int n, input logic [31:0] exp);
		int k;
		for (k = 0; k < n; k++) expQ.push_back(exp[8*k+:8]);
		host.frame(1'b1, a, n, 32'h0000_0000);
	endtask : rd

	task wr(input logic [14:0] a, input int n, input logic [31:0] d);
		host.frame(1'b0, a, n, d);
	endtask : wr

	task test_done();
		if (expQ.size() != 0) begin
			num_errors++;
			$display("Error at %0t: %0d read notes left over", $time, expQ.size());
		end
		if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done

	// ----------------------------------------
	// watchers
	// ----------------------------------------
	// compare each reported byte with the oldest note
	always @(posedge clk) begin
		if (rdStrobe === 1'b1) begin
			if (expQ.size() == 0) begin
				num_errors++;
				$display("Error at %0t: read byte with no note", $time);
			end else begin
				check_byte(rdByte, expQ.pop_front());
			end
		end
		if (crq === 1'b1) rstPulses++;
	end

	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		$display("Error at %0t: run timed out", $time);
		test_done();
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		reset = 1'b1;
		rng = 32'h0000_dd78;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		rd(15'h0000, 1, 32'h0000_0030);
		check_port(32'(asc), 32'h0000_0001);
		rd(15'h0003, 4, {REV, PID, 4'h0, CLS});
		rd(15'h000c, 2, {16'h0000, MKR});
		wr(15'h0003, 1, 32'h0000_00ff);
		rd(15'h0003, 1, {24'h0000_00, 4'hf, CLS});
		for (i = 0; i < 4; i++) begin
			r = xs();
			wr(15'h0002, 1, {24'h0000_00, r[7:2], i[1:0]});
			check_port(32'(pm), 32'(i[1:0]));
			rd(15'h0002, 1, {24'h0000_00, r[7:2], i[1:0]});
		end
		// stream across the reserved byte at 0x728
		r = xs();
		wr(15'h0727, 3, r);
		check_port(32'(dAdj), 32'(r[7:0]));
		check_port(32'(dDith), 32'(r[23:16]));
		rd(15'h0728, 1, 32'h0000_0000);
		r = xs();
		wr(15'h072a, 4, r);
		check_port(ofs, r);
		rd(15'h072e, 1, 32'h0000_0000);
		wr(15'h0000, 1, 32'h0000_000f);
		check_port(32'(asc), 32'h0000_0000);
		rd(15'h0000, 1, 32'h0000_001f);
		rd(15'h0006, 3, {8'h00, PID[7:0], PID[15:8], REV});
		wr(15'h0000, 1, 32'h0000_008f);
		check_port(32'(rstPulses), 32'h0000_0001);
		check_port({asc, pm, dAdj, dDith}, 32'h0004_0000);
		check_port(ofs, 32'h0000_0000);
		rd(15'h0000, 1, 32'h0000_0030);
		test_done();
	end
endmodule : spi_config_ident_regs_tb_top

`default_nettype wire
